// file: verilog/ndeac_map.vh
// Register select codes, control bit positions, unlock keys and timing for the NV access controller.
// Included by every design file of the block; definitions only.
`ifndef NDEAC_MAP_VH
`define NDEAC_MAP_VH

// Register select codes on the special function register port
`define NDEAC_SEL_W          4
`define NDEAC_SEL_TBL_UPPER  4'h0
`define NDEAC_SEL_TBL_HIGH   4'h1
`define NDEAC_SEL_TBL_LOW    4'h2
`define NDEAC_SEL_TBL_LATCH  4'h3
`define NDEAC_SEL_UNLOCK     4'h4
`define NDEAC_SEL_CONTROL    4'h5
`define NDEAC_SEL_DATA       4'h6
`define NDEAC_SEL_ADDR_LOW   4'h7
`define NDEAC_SEL_ADDR_HIGH  4'h8
`define NDEAC_SEL_PRIO_TWO   4'h9
`define NDEAC_SEL_FLAGS_TWO  4'hA
`define NDEAC_SEL_MASK_TWO   4'hB

// Control register bit positions
`define NDEAC_BIT_MSS        7
`define NDEAC_BIT_CSS        6
`define NDEAC_BIT_REE        4
`define NDEAC_BIT_FAULT      3
`define NDEAC_BIT_PE         2
`define NDEAC_BIT_LAUNCH     1
`define NDEAC_BIT_RD         0
// Completion flag position in the second peripheral flag register
`define NDEAC_BIT_DONE       4

// Field masks and reset values
`define NDEAC_ADDR_HIGH_MASK 8'h03
`define NDEAC_TBL_UPPER_MASK 8'h3F
`define NDEAC_BYTE_ZERO      8'h00
`define NDEAC_ERASED_BYTE    8'hFF

// Unlock keys and sequence states
`define NDEAC_KEY_FIRST      8'h55
`define NDEAC_KEY_SECOND     8'hAA
`define NDEAC_UNL_IDLE       2'b00
`define NDEAC_UNL_GOT_FIRST  2'b01
`define NDEAC_UNL_ARMED      2'b10

// Cycle targets
`define NDEAC_TGT_EEPROM     2'b00
`define NDEAC_TGT_FLASH      2'b01
`define NDEAC_TGT_CONFIG     2'b10

// Self-timed write duration
`define NDEAC_CLK_PERIOD_NS  8
`define NDEAC_WRITE_TIME_NS  4000000
`define NDEAC_TIMER_W        20
`define NDEAC_MEM_AW         10

`endif

// file: verilog/ndeac_byte_mem.v
// Data EEPROM array model: 1024 bytes, one write port, registered read data.
// Assumes address and write data are held stable by the caller while a strobe is high.
`timescale 1ns/1ps
`include "ndeac_map.vh"

module ndeac_byte_mem
(
  // Clock
  input  wire                      core_clk_i,
  // Access
  input  wire [`NDEAC_MEM_AW-1:0]  addr_i,
  input  wire                      we_i,
  input  wire [7:0]                wdata_i,
  input  wire                      re_i,
  output reg  [7:0]                rdata_o
);

  reg [7:0] cells [0:(1 << `NDEAC_MEM_AW)-1];

  // No reset: nonvolatile contents are not cleared by any reset
  always @(posedge core_clk_i)
  begin
    if (we_i)
      cells[addr_i] <= wdata_i;
    if (re_i)
      rdata_o <= cells[addr_i];
  end

endmodule // ndeac_byte_mem

// file: verilog/ndeac_cycle_timer.v
// Self-timed write cycle counter: runs for CYCLES clocks after start, can be aborted.
// Assumes start is a single-cycle pulse that is not raised while busy.
`timescale 1ns/1ps
`include "ndeac_map.vh"

module ndeac_cycle_timer
#(
  parameter [`NDEAC_TIMER_W-1:0] CYCLES = 20'd1
)
(
  // Clock and reset
  input  wire core_clk_i,
  input  wire rst_n_i,
  // Control
  input  wire start_i,
  input  wire abort_i,
  // Status
  output reg  busy_o,
  output wire done_o
);

  reg [`NDEAC_TIMER_W-1:0] remaining;

  assign done_o = busy_o && !abort_i && (remaining == {{(`NDEAC_TIMER_W-1){1'b0}}, 1'b1});

  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      busy_o    <= 1'b0;
      remaining <= {`NDEAC_TIMER_W{1'b0}};
    end
    else if (abort_i || done_o)
    begin
      busy_o    <= 1'b0;
      remaining <= {`NDEAC_TIMER_W{1'b0}};
    end
    else if (start_i && !busy_o)
    begin
      busy_o    <= 1'b1;
      remaining <= CYCLES;
    end
    else if (busy_o)
      remaining <= remaining - {{(`NDEAC_TIMER_W-1){1'b0}}, 1'b1};
  end

endmodule // ndeac_cycle_timer

// file: verilog/ndeac_top.v
// Nonvolatile access controller: data EEPROM read/write, flash and configuration cycle launch.
// Assumes firmware drives the register port on the instruction clock, one access per cycle.
//
// How it works
// - External pin or watchdog reset during a write leaves the fault flag set.
// - Flash writes and erases need the same unlock sequence before they start.
// - Data register carries the byte; low and high address registers form the location.
// - Low address picks one of 256 bytes; two high bits extend to 1024.
// - EEPROM byte write erases then programs; an internal timer sets the duration.
// - Bit 7 selects program flash when set, data EEPROM when clear.
// - Bit 6 set targets configuration space; clear lets bit 7 choose.
// - Bit 2 permits write cycles; cleared at power-up.
// - Fault flag sets with launch, clears when the timed write completes normally.
// - Launch bit starts a cycle; software only sets it, hardware clears at completion.
// - Completion sets the done flag; only firmware clears it.
// - Read strobe does a one-cycle read and self-clears; refused when a select bit set.
// - Unlock port stores nothing and always reads as zero.
// - Row erase enable makes the next flash launch an erase; completion of that erase clears it.
// - A recorded fault leaves both select bits untouched.
// - Read data appears the cycle after the strobe and holds until overwritten.
// - Power-on clears erase enable, program enable, launch, strobe; bit 5 reads zero.
// - Table pointer is 22 bits over three byte registers, plus an 8-bit latch.
// - Cycle starts only after 55h, then AAh to unlock, then launch, each time.
// - Launch needs program enable already set before the same write.
// - Control, address and data registers ignore writes while a cycle runs.
// - Writes are blocked during the power-up timer period.
`timescale 1ns/1ps
`include "ndeac_map.vh"

module ndeac_top
#(
  parameter integer WRITE_TIME_NS = `NDEAC_WRITE_TIME_NS
)
(
  // Clock and power-on reset
  input  wire                     core_clk_i,
  input  wire                     rst_n_i,
  // Device reset events and power-up timer
  input  wire                     external_reset_pin_i,
  input  wire                     watchdog_timeout_i,
  input  wire                     power_up_timer_active_i,
  // Special function register port
  input  wire [`NDEAC_SEL_W-1:0]  sfr_sel_i,
  input  wire                     sfr_wr_i,
  input  wire                     sfr_rd_i,
  input  wire [7:0]               sfr_wdata_i,
  output reg  [7:0]               sfr_rdata_o,
  // Flash and configuration cycle request
  output reg                      op_start_o,
  output reg                      op_done_o,
  output reg  [1:0]               op_target_o,
  output reg                      op_erase_o,
  output reg  [21:0]              op_addr_o,
  output reg  [7:0]               op_data_o,
  output wire                     cycle_busy_o,
  // Interrupt controller side
  output wire                     nvm_done_flag_o,
  output wire                     nvm_done_irq_mask_o,
  output wire                     nvm_done_priority_o
);

  // Derived cycle count, rounded up, never below one
  localparam integer WRITE_CYC_RAW = (WRITE_TIME_NS + `NDEAC_CLK_PERIOD_NS - 1) / `NDEAC_CLK_PERIOD_NS;
  localparam integer WRITE_CYC     = (WRITE_CYC_RAW < 1) ? 1 : WRITE_CYC_RAW;

  // Register file
  reg  [7:0] table_pointer_upper;
  reg  [7:0] table_pointer_high;
  reg  [7:0] table_pointer_low;
  reg  [7:0] table_latch_byte;
  reg  [7:0] nvm_data;
  reg  [7:0] nvm_address_low;
  reg  [7:0] nvm_address_high;
  reg  [7:0] peripheral_priority_two;
  reg  [7:0] peripheral_flags_two;
  reg  [7:0] peripheral_irq_mask_two;
  // Control register fields
  reg        memory_space_select;
  reg        config_space_select;
  reg        row_erase_enable;
  reg        cycle_fault_flag;
  reg        program_enable;
  reg        launch;
  reg        read_strobe;
  // Sequencing
  reg  [1:0] unlock_state;
  reg  [1:0] next_unlock_state;
  reg        read_pending;
  reg  [1:0] cycle_target;
  reg        cycle_erase;

  wire       busy;
  wire       cycle_done;
  wire [7:0] mem_q;
  wire [7:0] nvm_control;

  wire reset_event = external_reset_pin_i || watchdog_timeout_i;
  wire any_wr      = sfr_wr_i && !reset_event;
  wire wr_ctrl     = any_wr && (sfr_sel_i == `NDEAC_SEL_CONTROL);
  wire wr_unlock   = any_wr && (sfr_sel_i == `NDEAC_SEL_UNLOCK);
  // Registers tied to a running cycle stay frozen so the array sees stable inputs
  wire ctrl_open   = !busy;

  // Launch is taken only straight after the full key pair, with enable already set
  wire launch_req  = wr_ctrl && sfr_wdata_i[`NDEAC_BIT_LAUNCH] && ctrl_open
                     && (unlock_state == `NDEAC_UNL_ARMED)
                     && program_enable
                     && !power_up_timer_active_i;

  wire next_css    = sfr_wdata_i[`NDEAC_BIT_CSS];
  wire next_mss    = sfr_wdata_i[`NDEAC_BIT_MSS];
  // Launch uses the select bits as stored before this write
  wire [1:0] launch_target = config_space_select ? `NDEAC_TGT_CONFIG :
                             (memory_space_select ? `NDEAC_TGT_FLASH :
                              `NDEAC_TGT_EEPROM);
  wire launch_erase = row_erase_enable && (launch_target == `NDEAC_TGT_FLASH);

  // Read refused whenever either select bit of the written value is set
  wire read_req    = wr_ctrl && ctrl_open && sfr_wdata_i[`NDEAC_BIT_RD]
                     && !next_mss && !next_css;

  // EEPROM erase-before-write: erased pattern at launch, new byte at completion
  wire ee_launch   = launch_req && (launch_target == `NDEAC_TGT_EEPROM);
  wire ee_done     = cycle_done && (cycle_target == `NDEAC_TGT_EEPROM);
  wire mem_we      = ee_launch || ee_done;
  wire [7:0] mem_wdata = ee_launch ? `NDEAC_ERASED_BYTE : nvm_data;
  wire [`NDEAC_MEM_AW-1:0] mem_addr = {nvm_address_high[1:0], nvm_address_low};

  assign nvm_control = {memory_space_select, config_space_select, 1'b0,
                        row_erase_enable, cycle_fault_flag, program_enable,
                        launch, read_strobe};
  assign cycle_busy_o        = busy;
  assign nvm_done_flag_o     = peripheral_flags_two[`NDEAC_BIT_DONE];
  assign nvm_done_irq_mask_o = peripheral_irq_mask_two[`NDEAC_BIT_DONE];
  assign nvm_done_priority_o = peripheral_priority_two[`NDEAC_BIT_DONE];

  ndeac_cycle_timer
  #(
    .CYCLES (WRITE_CYC[`NDEAC_TIMER_W-1:0])
  )
  u_timer
  (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .start_i    (launch_req),
    .abort_i    (reset_event),
    .busy_o     (busy),
    .done_o     (cycle_done)
  );

  ndeac_byte_mem u_mem
  (
    .core_clk_i (core_clk_i),
    .addr_i     (mem_addr),
    .we_i       (mem_we),
    .wdata_i    (mem_wdata),
    .re_i       (read_req),
    .rdata_o    (mem_q)
  );

  // Unlock sequence: any write that is not the expected next step starts over
  always @*
  begin
    next_unlock_state = unlock_state;
    if (reset_event)
      next_unlock_state = `NDEAC_UNL_IDLE;
    else if (wr_unlock)
    begin
      case (unlock_state)
        `NDEAC_UNL_IDLE,
        `NDEAC_UNL_ARMED:
          next_unlock_state = (sfr_wdata_i == `NDEAC_KEY_FIRST) ? `NDEAC_UNL_GOT_FIRST : `NDEAC_UNL_IDLE;
        `NDEAC_UNL_GOT_FIRST:
          next_unlock_state = (sfr_wdata_i == `NDEAC_KEY_SECOND) ? `NDEAC_UNL_ARMED :
                              ((sfr_wdata_i == `NDEAC_KEY_FIRST) ? `NDEAC_UNL_GOT_FIRST : `NDEAC_UNL_IDLE);
        default:
          next_unlock_state = `NDEAC_UNL_IDLE;
      endcase
    end
    else if (any_wr)
      next_unlock_state = `NDEAC_UNL_IDLE;
  end

  // Control register
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      memory_space_select <= 1'b0;
      config_space_select <= 1'b0;
      row_erase_enable    <= 1'b0;
      cycle_fault_flag    <= 1'b0;
      program_enable      <= 1'b0;
      launch              <= 1'b0;
      read_strobe         <= 1'b0;
      unlock_state        <= `NDEAC_UNL_IDLE;
      read_pending        <= 1'b0;
      cycle_target        <= `NDEAC_TGT_EEPROM;
      cycle_erase         <= 1'b0;
    end
    else
    begin
      unlock_state <= next_unlock_state;
      read_pending <= read_req;
      if (reset_event)
      begin
        // Select bits and fault flag survive so firmware can see what was cut short
        row_erase_enable <= 1'b0;
        program_enable   <= 1'b0;
        launch           <= 1'b0;
        read_strobe      <= 1'b0;
      end
      else if (cycle_done)
      begin
        launch           <= 1'b0;
        cycle_fault_flag <= 1'b0;
        if (cycle_erase)
          row_erase_enable <= 1'b0;
      end
      else if (wr_ctrl && ctrl_open)
      begin
        memory_space_select <= next_mss;
        config_space_select <= next_css;
        row_erase_enable    <= sfr_wdata_i[`NDEAC_BIT_REE];
        program_enable      <= sfr_wdata_i[`NDEAC_BIT_PE];
        // Launch wins over any fault value written alongside it
        cycle_fault_flag    <= launch_req ? 1'b1 : sfr_wdata_i[`NDEAC_BIT_FAULT];
        if (launch_req)
        begin
          launch       <= 1'b1;
          cycle_target <= launch_target;
          cycle_erase  <= launch_erase;
        end
        // A control write right after a read must still let the strobe self-clear
        read_strobe <= read_req;
      end
      else if (read_pending)
        read_strobe <= 1'b0;
    end
  end

  // Data, address and table registers
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      table_pointer_upper <= `NDEAC_BYTE_ZERO;
      table_pointer_high  <= `NDEAC_BYTE_ZERO;
      table_pointer_low   <= `NDEAC_BYTE_ZERO;
      table_latch_byte    <= `NDEAC_BYTE_ZERO;
      nvm_data            <= `NDEAC_BYTE_ZERO;
      nvm_address_low     <= `NDEAC_BYTE_ZERO;
      nvm_address_high    <= `NDEAC_BYTE_ZERO;
    end
    else
    begin
      if (read_pending)
        nvm_data <= mem_q;
      else if (any_wr && ctrl_open && sfr_sel_i == `NDEAC_SEL_DATA)
        nvm_data <= sfr_wdata_i;
      if (any_wr && ctrl_open && sfr_sel_i == `NDEAC_SEL_ADDR_LOW)
        nvm_address_low <= sfr_wdata_i;
      if (any_wr && ctrl_open && sfr_sel_i == `NDEAC_SEL_ADDR_HIGH)
        nvm_address_high <= sfr_wdata_i & `NDEAC_ADDR_HIGH_MASK;
      // Table registers also feed a running flash cycle, so they freeze too
      if (any_wr && ctrl_open && sfr_sel_i == `NDEAC_SEL_TBL_UPPER)
        table_pointer_upper <= sfr_wdata_i & `NDEAC_TBL_UPPER_MASK;
      if (any_wr && ctrl_open && sfr_sel_i == `NDEAC_SEL_TBL_HIGH)
        table_pointer_high <= sfr_wdata_i;
      if (any_wr && ctrl_open && sfr_sel_i == `NDEAC_SEL_TBL_LOW)
        table_pointer_low <= sfr_wdata_i;
      if (any_wr && ctrl_open && sfr_sel_i == `NDEAC_SEL_TBL_LATCH)
        table_latch_byte <= sfr_wdata_i;
    end
  end

  // Peripheral flag, mask and priority registers
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      peripheral_priority_two <= `NDEAC_BYTE_ZERO;
      peripheral_flags_two    <= `NDEAC_BYTE_ZERO;
      peripheral_irq_mask_two <= `NDEAC_BYTE_ZERO;
    end
    else
    begin
      if (any_wr && sfr_sel_i == `NDEAC_SEL_PRIO_TWO)
        peripheral_priority_two <= sfr_wdata_i;
      if (any_wr && sfr_sel_i == `NDEAC_SEL_MASK_TWO)
        peripheral_irq_mask_two <= sfr_wdata_i;
      if (any_wr && sfr_sel_i == `NDEAC_SEL_FLAGS_TWO)
        peripheral_flags_two <= sfr_wdata_i;
      // Completion in the same cycle as a clearing write still sets the flag
      if (cycle_done)
        peripheral_flags_two[`NDEAC_BIT_DONE] <= 1'b1;
    end
  end

  // Flash and configuration cycle request outputs
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      op_start_o  <= 1'b0;
      op_done_o   <= 1'b0;
      op_target_o <= `NDEAC_TGT_EEPROM;
      op_erase_o  <= 1'b0;
      op_addr_o   <= 22'h000000;
      op_data_o   <= `NDEAC_BYTE_ZERO;
    end
    else
    begin
      op_start_o <= launch_req;
      op_done_o  <= cycle_done;
      if (launch_req)
      begin
        op_target_o <= launch_target;
        op_erase_o  <= launch_erase;
        op_addr_o   <= {table_pointer_upper[5:0], table_pointer_high, table_pointer_low};
        op_data_o   <= table_latch_byte;
      end
    end
  end

  // Register read port, one cycle latency
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sfr_rdata_o <= `NDEAC_BYTE_ZERO;
    else if (sfr_rd_i)
    begin
      case (sfr_sel_i)
        `NDEAC_SEL_TBL_UPPER: sfr_rdata_o <= table_pointer_upper;
        `NDEAC_SEL_TBL_HIGH:  sfr_rdata_o <= table_pointer_high;
        `NDEAC_SEL_TBL_LOW:   sfr_rdata_o <= table_pointer_low;
        `NDEAC_SEL_TBL_LATCH: sfr_rdata_o <= table_latch_byte;
        `NDEAC_SEL_UNLOCK:    sfr_rdata_o <= `NDEAC_BYTE_ZERO;
        `NDEAC_SEL_CONTROL:   sfr_rdata_o <= nvm_control;
        `NDEAC_SEL_DATA:      sfr_rdata_o <= nvm_data;
        `NDEAC_SEL_ADDR_LOW:  sfr_rdata_o <= nvm_address_low;
        `NDEAC_SEL_ADDR_HIGH: sfr_rdata_o <= nvm_address_high;
        `NDEAC_SEL_PRIO_TWO:  sfr_rdata_o <= peripheral_priority_two;
        `NDEAC_SEL_FLAGS_TWO: sfr_rdata_o <= peripheral_flags_two;
        `NDEAC_SEL_MASK_TWO:  sfr_rdata_o <= peripheral_irq_mask_two;
        default:              sfr_rdata_o <= `NDEAC_BYTE_ZERO;
      endcase
    end
  end

endmodule // ndeac_top

// file: verif/ndeac_fw_model.sv
// Firmware model: performs register port accesses one at a time on the instruction clock.
// Assumes the register port samples its strobes on the rising clock edge.
`timescale 1ns/1ps
`include "ndeac_map.vh"

module ndeac_fw_model
(
  // Clock
  input  wire       core_clk_i,
  // Register port
  output reg  [3:0] sfr_sel_o,
  output reg        sfr_wr_o,
  output reg        sfr_rd_o,
  output reg  [7:0] sfr_wdata_o,
  input  wire [7:0] sfr_rdata_i
);
  initial
  begin
    sfr_sel_o   = 4'h0;
    sfr_wr_o    = 1'b0;
    sfr_rd_o    = 1'b0;
    sfr_wdata_o = 8'h00;
  end

  task wr(input [3:0] s, input [7:0] d);
    @(posedge core_clk_i);
    sfr_sel_o   <= s;
    sfr_wdata_o <= d;
    sfr_wr_o    <= 1'b1;
    @(posedge core_clk_i);
    sfr_wr_o    <= 1'b0;
    // Released data lines do not keep the last value
    sfr_wdata_o <= ~d;
  endtask

  // Data is taken once the registered answer has landed
  task rd(input [3:0] s, output [7:0] d);
    @(posedge core_clk_i);
    sfr_sel_o <= s;
    sfr_rd_o  <= 1'b1;
    @(posedge core_clk_i);
    sfr_rd_o  <= 1'b0;
    #1;
    d = sfr_rdata_i;
  endtask

  task launch(input [7:0] ctl);
    wr(`NDEAC_SEL_UNLOCK, `NDEAC_KEY_FIRST);
    wr(`NDEAC_SEL_UNLOCK, `NDEAC_KEY_SECOND);
    wr(`NDEAC_SEL_CONTROL, ctl);
  endtask
endmodule // ndeac_fw_model

// file: verif/ndeac_top_monitor.sv
// Checker for the NV access controller, bound to the top module's ports.
// Assumes the clock period of the block's map header.
`timescale 1ns/1ps
`include "ndeac_map.vh"

module ndeac_top_monitor
#(
  parameter integer WRITE_TIME_NS = 80
)
(
  // Clock and reset
  input wire        core_clk_i,
  input wire        rst_n_i,
  // Inputs
  input wire        external_reset_pin_i,
  input wire        watchdog_timeout_i,
  input wire        power_up_timer_active_i,
  input wire [3:0]  sfr_sel_i,
  input wire        sfr_wr_i,
  input wire        sfr_rd_i,
  input wire [7:0]  sfr_wdata_i,
  // Outputs
  input wire [7:0]  sfr_rdata_o,
  input wire        op_start_o,
  input wire        op_done_o,
  input wire [1:0]  op_target_o,
  input wire        op_erase_o,
  input wire        cycle_busy_o,
  input wire        nvm_done_flag_o
);
  localparam integer CYC = WRITE_TIME_NS / `NDEAC_CLK_PERIOD_NS;
  wire ev = external_reset_pin_i | watchdog_timeout_i;
  wire lw = sfr_wr_i && sfr_sel_i == `NDEAC_SEL_CONTROL && sfr_wdata_i[`NDEAC_BIT_LAUNCH];
  wire fc = sfr_wr_i && sfr_sel_i == `NDEAC_SEL_FLAGS_TWO;
  wire rc = sfr_rd_i && sfr_sel_i == `NDEAC_SEL_CONTROL;
  reg  [15:0] n;

  // Busy-cycle count, read when busy falls
  always @(posedge core_clk_i or negedge rst_n_i)
    if (!rst_n_i)
      n <= 16'h0000;
    else
      n <= cycle_busy_o ? n + 16'h0001 : 16'h0000;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_len; $fell(cycle_busy_o) && !$past(ev) |-> n >= CYC - 2 && n <= CYC; endproperty
  a_len: assert property (p_len) else $error("timed cycle length wrong");
  // Flag and done pulse are both registered off the same completion edge that drops busy
  property p_done; $fell(cycle_busy_o) && !$past(ev) |-> nvm_done_flag_o && op_done_o; endproperty
  a_done: assert property (p_done) else $error("completion not flagged");
  property p_sticky; nvm_done_flag_o && !fc && !ev |=> nvm_done_flag_o; endproperty
  a_sticky: assert property (p_sticky) else $error("done flag cleared by hardware");
  property p_start; op_start_o |-> cycle_busy_o && $past(lw); endproperty
  a_start: assert property (p_start) else $error("cycle started without launch write");
  property p_pt; power_up_timer_active_i |=> !op_start_o; endproperty
  a_pt: assert property (p_pt) else $error("launch during power-up timer");
  property p_unlock; sfr_rd_i && sfr_sel_i == `NDEAC_SEL_UNLOCK |=> sfr_rdata_o == 8'h00; endproperty
  a_unlock: assert property (p_unlock) else $error("unlock port read not zero");
  property p_bit5; rc |=> !sfr_rdata_o[5]; endproperty
  a_bit5: assert property (p_bit5) else $error("control bit 5 reads one");
  property p_lock; rc && cycle_busy_o |=> sfr_rdata_o[1] && sfr_rdata_o[3]; endproperty
  a_lock: assert property (p_lock) else $error("launch or fault clear while busy");
  property p_erase; op_start_o && op_erase_o |-> op_target_o == `NDEAC_TGT_FLASH; endproperty
  a_erase: assert property (p_erase) else $error("erase on non flash target");
endmodule // ndeac_top_monitor

bind ndeac_top ndeac_top_monitor #(.WRITE_TIME_NS(WRITE_TIME_NS)) u_mon
(
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .external_reset_pin_i(external_reset_pin_i),
  .watchdog_timeout_i(watchdog_timeout_i), .power_up_timer_active_i(power_up_timer_active_i),
  .sfr_sel_i(sfr_sel_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
  .sfr_rdata_o(sfr_rdata_o), .op_start_o(op_start_o), .op_done_o(op_done_o), .op_target_o(op_target_o),
  .op_erase_o(op_erase_o), .cycle_busy_o(cycle_busy_o), .nvm_done_flag_o(nvm_done_flag_o)
);

// file: verif/ndeac_top_bench.sv
// Testbench for the NV access controller; the firmware model drives the register port.
// Assumes a 10-cycle timed write (WRITE_TIME_NS of 80 at 8 ns).
`timescale 1ns/1ps
`include "ndeac_map.vh"

module ndeac_top_bench;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i    = 1'b0;
  logic        ext_rst    = 1'b0;
  logic        wdt_rst    = 1'b0;
  logic        pt_act     = 1'b0;
  wire  [3:0]  sel;
  wire         wr;
  wire         rd;
  wire  [7:0]  wdata;
  wire  [7:0]  rdata;
  wire         start;
  wire         erase;
  wire         busy;
  wire         flag;
  wire         msk;
  wire         pri;
  wire  [1:0]  tgt;
  wire  [21:0] addr;
  wire         done;
  wire  [7:0]  odata;
  logic [7:0]  v;
  logic [7:0]  got_dt;
  logic        got_st;
  logic        got_er;
  logic [1:0]  got_tgt;
  logic [21:0] got_ad;
  integer      err_total = 0;
  integer      samples_checked = 0;

  always #4 core_clk_i = ~core_clk_i;

  ndeac_top #(.WRITE_TIME_NS(80)) dut
  (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .external_reset_pin_i(ext_rst),
    .watchdog_timeout_i(wdt_rst), .power_up_timer_active_i(pt_act), .sfr_sel_i(sel), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .op_start_o(start), .op_done_o(done),
    .op_target_o(tgt), .op_erase_o(erase), .op_addr_o(addr), .op_data_o(odata), .cycle_busy_o(busy),
    .nvm_done_flag_o(flag), .nvm_done_irq_mask_o(msk), .nvm_done_priority_o(pri)
  );

  ndeac_fw_model u_fw
  (
    .core_clk_i(core_clk_i), .sfr_sel_o(sel), .sfr_wr_o(wr), .sfr_rd_o(rd),
    .sfr_wdata_o(wdata), .sfr_rdata_i(rdata)
  );

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task stop_test;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task wait_start;
    integer i;
    got_st = 1'b0;
    for (i = 0; i < 4 && !got_st; i = i + 1)
    begin
      #1;
      if (start === 1'b1)
      begin
        got_st  = 1'b1;
        got_er  = erase;
        got_tgt = tgt;
        got_ad  = addr;
        got_dt  = odata;
      end
      @(posedge core_clk_i);
    end
  endtask

  task wait_idle;
    integer i;
    for (i = 0; i < 40 && busy !== 1'b0; i = i + 1)
    begin
      @(posedge core_clk_i);
      #1;
    end
    if (busy !== 1'b0)
    begin
      chk("idle", busy, 0);
      stop_test;
    end
  endtask

  task s_reset_vals;
    u_fw.rd(`NDEAC_SEL_CONTROL, v);
    chk("ctl", v & 8'h37, 8'h00);
    u_fw.rd(`NDEAC_SEL_UNLOCK, v);
    chk("unl", v, 8'h00);
    u_fw.wr(`NDEAC_SEL_MASK_TWO, 8'h10);
    u_fw.wr(`NDEAC_SEL_PRIO_TWO, 8'h10);
    #1;
    chk("irq", {msk, pri}, 2'b11);
  endtask

  task s_ee_write;
    u_fw.wr(`NDEAC_SEL_ADDR_LOW, 8'h5A);
    u_fw.wr(`NDEAC_SEL_ADDR_HIGH, 8'hFF);
    u_fw.rd(`NDEAC_SEL_ADDR_HIGH, v);
    chk("adh", v, 8'h03);
    u_fw.wr(`NDEAC_SEL_DATA, 8'hC3);
    u_fw.wr(`NDEAC_SEL_CONTROL, 8'h04);
    u_fw.launch(8'h06);
    wait_start;
    chk("start", {got_st, got_tgt}, {1'b1, `NDEAC_TGT_EEPROM});
    // Locked address write: a broken lock would read back another location
    u_fw.wr(`NDEAC_SEL_ADDR_LOW, 8'h00);
    u_fw.rd(`NDEAC_SEL_CONTROL, v);
    chk("busyctl", v & 8'h0E, 8'h0E);
    wait_idle;
    chk("opdone", done, 1);
    u_fw.rd(`NDEAC_SEL_CONTROL, v);
    chk("donectl", v & 8'h0A, 8'h00);
    chk("flag", flag, 1);
    u_fw.wr(`NDEAC_SEL_DATA, 8'h00);
    u_fw.wr(`NDEAC_SEL_CONTROL, 8'h01);
    u_fw.rd(`NDEAC_SEL_DATA, v);
    chk("data", v, 8'hC3);
    u_fw.wr(`NDEAC_SEL_FLAGS_TWO, 8'h00);
    u_fw.rd(`NDEAC_SEL_FLAGS_TWO, v);
    chk("flagclr", v[4], 0);
  endtask

  task s_refuse;
    u_fw.wr(`NDEAC_SEL_CONTROL, 8'h00);
    u_fw.launch(8'h06);
    wait_start;
    chk("nope", got_st, 0);
    u_fw.wr(`NDEAC_SEL_CONTROL, 8'h04);
    u_fw.wr(`NDEAC_SEL_CONTROL, 8'h06);
    wait_start;
    chk("nokey", got_st, 0);
    pt_act <= 1'b1;
    u_fw.launch(8'h06);
    wait_start;
    chk("pwrt", got_st, 0);
    pt_act <= 1'b0;
  endtask

  task s_flash;
    u_fw.wr(`NDEAC_SEL_TBL_UPPER, 8'hFF);
    u_fw.wr(`NDEAC_SEL_TBL_HIGH, 8'h12);
    u_fw.wr(`NDEAC_SEL_TBL_LOW, 8'h34);
    u_fw.wr(`NDEAC_SEL_TBL_LATCH, 8'hA5);
    u_fw.wr(`NDEAC_SEL_CONTROL, 8'h94);
    u_fw.launch(8'h96);
    wait_start;
    chk("ferase", {got_st, got_er, got_tgt}, 4'b1101);
    chk("fadr", got_ad, 22'h3F1234);
    chk("fdat", got_dt, 8'hA5);
    wait_idle;
    u_fw.rd(`NDEAC_SEL_CONTROL, v);
    chk("ree", v & 8'h90, 8'h80);
    u_fw.wr(`NDEAC_SEL_DATA, 8'h77);
    u_fw.wr(`NDEAC_SEL_CONTROL, 8'h81);
    u_fw.wr(`NDEAC_SEL_CONTROL, 8'h41);
    u_fw.rd(`NDEAC_SEL_DATA, v);
    chk("rdref", v, 8'h77);
    u_fw.wr(`NDEAC_SEL_CONTROL, 8'h44);
    u_fw.launch(8'h46);
    wait_start;
    chk("cfg", got_tgt, `NDEAC_TGT_CONFIG);
    wait_idle;
  endtask

  task s_abort(input logic wd);
    u_fw.wr(`NDEAC_SEL_CONTROL, 8'h84);
    u_fw.launch(8'h86);
    repeat (3) @(posedge core_clk_i);
    wdt_rst <= wd;
    ext_rst <= ~wd;
    @(posedge core_clk_i);
    wdt_rst <= 1'b0;
    ext_rst <= 1'b0;
    wait_idle;
    chk("abdone", done, 0);
    u_fw.rd(`NDEAC_SEL_CONTROL, v);
    chk("abort", v & 8'hCE, 8'h88);
  endtask

  initial
  begin
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    s_reset_vals;
    s_ee_write;
    s_refuse;
    s_flash;
    s_abort(1'b0);
    s_abort(1'b1);
    stop_test;
  end
endmodule // ndeac_top_bench
